/* File: rtl/qemt_params.svh */
// register map, field positions, reset values and prescaler taps of the match timer
// assumes inclusion by bare name from the timer top module and testbench
`ifndef QEMT_PARAMS_SVH
`define QEMT_PARAMS_SVH
`define QEMT_ADDR_BITS    8
`define QEMT_OFF_COUNT    8'h00
`define QEMT_OFF_CONST_A  8'h04
`define QEMT_OFF_CONST_B  8'h08
`define QEMT_OFF_CONTROL  8'h0c
`define QEMT_OFF_STATUS   8'h10
`define QEMT_CHAN_STRIDE  8'h20
`define QEMT_PAIR_BASE    8'h80
`define QEMT_PAIR_STRIDE  8'h10
`define QEMT_RST_COUNT    8'h00
`define QEMT_RST_CONST    8'hff
`define QEMT_RST_CONTROL  8'h00
`define QEMT_RST_OUT_SEL  4'h0
`define QEMT_BIT_MB_IE    7
`define QEMT_BIT_MA_IE    6
`define QEMT_BIT_WRAP_IE  5
`define QEMT_BIT_CLR_HI   4
`define QEMT_BIT_CLR_LO   3
`define QEMT_BIT_CKS_HI   2
`define QEMT_BIT_CKS_LO   0
`define QEMT_BIT_FLAG_B   7
`define QEMT_BIT_FLAG_A   6
`define QEMT_BIT_FLAG_W   5
`define QEMT_BIT_OS_B_HI  3
`define QEMT_BIT_OS_B_LO  2
`define QEMT_BIT_OS_A_HI  1
`define QEMT_BIT_OS_A_LO  0
`define QEMT_PRESCALE_BITS 13
`define QEMT_DIV8_MSB     2
`define QEMT_DIV64_MSB    5
`define QEMT_DIV8192_MSB  12
`endif

/* File: rtl/qemt_pkg.sv */
// types of the four-channel match timer
// assumes nothing beyond the constants header
package qemt_pkg;
  typedef enum logic [2:0] {
    CKS_OFF, CKS_DIV8, CKS_DIV64, CKS_DIV8192,
    CKS_CASCADE, CKS_EXT_RISE, CKS_EXT_FALL, CKS_EXT_BOTH
  } qemt_cks_t;
  typedef enum logic [1:0] {CLR_NONE, CLR_MATCH_A, CLR_MATCH_B, CLR_EXT} qemt_clr_t;
  typedef enum logic [1:0] {OS_KEEP, OS_LOW, OS_HIGH, OS_TOGGLE} qemt_os_t;
endpackage

/* File: rtl/qemt_top.sv */
// four-channel 8-bit match timer with APB register slave
// assumes one clock pclk; pins are asynchronous and synchronised here
`timescale 1ns/1ps
`include "qemt_params.svh"
//
// Behaviour
// - each channel has an 8-bit up-counter stepping once per count event
// - channel pairs expose 16-bit word registers for counter and both constants
// - counter wrap from ff to 00 sets the wrap flag
// - counters reset to zero
// - counter equal to constant A sets match flag A
// - counter equal to constant B sets match flag B
// - match detection suppressed during access phase of a write to that constant
// - both match constants reset to all ones
// - output pin changes on matches as output-select fields choose
// - match B interrupt only while flag B and enable bit 7 are set
// - match A interrupt only while flag A and enable bit 6 are set
// - wrap interrupt only while wrap flag and enable bit 5 are set
// - clear select 00 never, 01 on match A, 10 on match B
// - clear select 11 clears on rising edge of pair reset pin
// - clock select 000 gives no count
// - codes 001 010 011 count falling edges of clock over 8, 64, 8192
// - code 100 makes upper channel count partner overflows
// - code 100 makes lower channel count partner match A events
// - codes 101 110 111 count rising, falling or both pin edges
// - each pair shares clock and reset pins; each channel has own output
// - match A output select: keep, low, high, toggle
// - match B output select uses same encoding
// - flag cleared by reading one then writing zero; writing one ignored
module qemt_top (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pair pins
  input  wire logic        pair_a_ext_clock_pin,
  input  wire logic        pair_a_ext_reset_pin,
  input  wire logic        pair_b_ext_clock_pin,
  input  wire logic        pair_b_ext_reset_pin,
  // channel outputs and requests
  output logic [3:0]       channel_output_pin,
  output logic [3:0]       match_a_irq,
  output logic [3:0]       match_b_irq,
  output logic [3:0]       wrap_irq
);

  default clocking cb_clk @(posedge pclk); endclocking
  default disable iff (!presetn);

  // address of one channel register, or of the pair word holding it
  function automatic logic hit(input logic [7:0] addr, input logic [1:0] ch, input logic [7:0] off);
    logic [7:0] single;
    logic [7:0] pair;
    single = 8'({6'h00, ch} * `QEMT_CHAN_STRIDE) + off;
    pair   = `QEMT_PAIR_BASE + (ch[1] ? `QEMT_PAIR_STRIDE : 8'h00) + off;
    hit    = (addr == single) || ((off < `QEMT_OFF_CONTROL) && (addr == pair));
  endfunction

  // upper channel of a pair sits in bits 15:8 of the word
  function automatic logic upper_lane(input logic [7:0] addr, input logic [1:0] ch);
    upper_lane = (addr >= `QEMT_PAIR_BASE) && !ch[0];
  endfunction

  function automatic logic apply_os(input logic [1:0] os, input logic val);
    case (qemt_pkg::qemt_os_t'(os))
      qemt_pkg::OS_KEEP:   apply_os = val;
      qemt_pkg::OS_LOW:    apply_os = 1'b0;
      qemt_pkg::OS_HIGH:   apply_os = 1'b1;
      qemt_pkg::OS_TOGGLE: apply_os = !val;
      default:             apply_os = val;
    endcase
  endfunction

  logic [7:0]  cnt       [4];
  logic [7:0]  const_a   [4];
  logic [7:0]  const_b   [4];
  logic [7:0]  ctrl      [4];
  logic [3:0]  out_sel   [4];
  logic [3:0]  flag_a;
  logic [3:0]  flag_b;
  logic [3:0]  flag_w;
  logic [3:0]  ma;
  logic [3:0]  mb;
  logic [3:0]  inc;
  logic [3:0]  wrap_evt;
  logic [3:0]  clr;
  logic [1:0]  ext_clk_pin;
  logic [1:0]  ext_rst_pin;
  logic [1:0]  clk_rise;
  logic [1:0]  clk_fall;
  logic [1:0]  rst_rise;
  logic [12:0] prescale;
  logic        tick8;
  logic        tick64;
  logic        tick8192;
  logic        acc;
  logic        done;
  logic        mapped;
  logic [31:0] next_rdata;

  assign ext_clk_pin = {pair_b_ext_clock_pin, pair_a_ext_clock_pin};
  assign ext_rst_pin = {pair_b_ext_reset_pin, pair_a_ext_reset_pin};

  // apb: one wait state so read data comes from a flop
  assign acc  = psel && penable;
  assign done = acc && pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc && !pready;
      pslverr <= acc && !pready && !mapped;
      if (acc && !pready) begin
        prdata <= pwrite ? 32'h0000_0000 : next_rdata;
      end
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    mapped     = 1'b0;
    for (int c = 0; c < 4; c++) begin
      if (hit(paddr, 2'(c), `QEMT_OFF_COUNT)) begin
        mapped = 1'b1;
        next_rdata = next_rdata | (upper_lane(paddr, 2'(c)) ? {16'h0000, cnt[c], 8'h00} : {24'h000000, cnt[c]});
      end
      if (hit(paddr, 2'(c), `QEMT_OFF_CONST_A)) begin
        mapped = 1'b1;
        next_rdata = next_rdata | (upper_lane(paddr, 2'(c)) ? {16'h0000, const_a[c], 8'h00} : {24'h000000, const_a[c]});
      end
      if (hit(paddr, 2'(c), `QEMT_OFF_CONST_B)) begin
        mapped = 1'b1;
        next_rdata = next_rdata | (upper_lane(paddr, 2'(c)) ? {16'h0000, const_b[c], 8'h00} : {24'h000000, const_b[c]});
      end
      if (hit(paddr, 2'(c), `QEMT_OFF_CONTROL)) begin
        mapped = 1'b1;
        next_rdata = {24'h000000, ctrl[c]};
      end
      if (hit(paddr, 2'(c), `QEMT_OFF_STATUS)) begin
        mapped = 1'b1;
        next_rdata = {24'h000000, flag_b[c], flag_a[c], flag_w[c], 1'b0, out_sel[c]};
      end
    end
  end

  // free-running prescaler; a tap's falling edge is its all-ones rollover
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale <= 13'h0000;
    end else begin
      prescale <= prescale + 13'h0001;
    end
  end
  assign tick8    = &prescale[`QEMT_DIV8_MSB:0];
  assign tick64   = &prescale[`QEMT_DIV64_MSB:0];
  assign tick8192 = &prescale[`QEMT_DIV8192_MSB:0];

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_pair
      logic [1:0] clk_meta;
      logic [1:0] clk_sync;
      logic [1:0] rst_meta;
      logic [1:0] rst_sync;
      // three flops, then a fourth stage for edge detection
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          clk_meta <= 2'b00;
          clk_sync <= 2'b00;
          rst_meta <= 2'b00;
          rst_sync <= 2'b00;
        end else begin
          clk_meta <= {clk_meta[0], ext_clk_pin[p]};
          clk_sync <= {clk_sync[0], clk_meta[1]};
          rst_meta <= {rst_meta[0], ext_rst_pin[p]};
          rst_sync <= {rst_sync[0], rst_meta[1]};
        end
      end
      assign clk_rise[p] = clk_sync[0] && !clk_sync[1];
      assign clk_fall[p] = !clk_sync[0] && clk_sync[1];
      assign rst_rise[p] = rst_sync[0] && !rst_sync[1];
    end
  endgenerate

  genvar c;
  generate
    for (c = 0; c < 4; c++) begin : g_chan
      localparam int PARTNER = c ^ 1;
      qemt_pkg::qemt_cks_t cks;
      qemt_pkg::qemt_clr_t csel;
      logic wr_cnt;
      logic wr_ca;
      logic wr_cb;
      logic wr_ctrl;
      logic wr_stat;
      logic rd_stat;
      logic sup_a;
      logic sup_b;
      logic eq_a;
      logic eq_b;
      logic eq_a_d;
      logic eq_b_d;
      logic both_cascade;
      logic cascade_src;
      logic seen_a;
      logic seen_b;
      logic seen_w;
      logic [7:0] wbyte;
      logic pin_a;

      assign cks     = qemt_pkg::qemt_cks_t'(ctrl[c][`QEMT_BIT_CKS_HI:`QEMT_BIT_CKS_LO]);
      assign csel    = qemt_pkg::qemt_clr_t'(ctrl[c][`QEMT_BIT_CLR_HI:`QEMT_BIT_CLR_LO]);
      assign wbyte   = upper_lane(paddr, 2'(c)) ? pwdata[15:8] : pwdata[7:0];
      assign wr_cnt  = done && pwrite && hit(paddr, 2'(c), `QEMT_OFF_COUNT);
      assign wr_ca   = done && pwrite && hit(paddr, 2'(c), `QEMT_OFF_CONST_A);
      assign wr_cb   = done && pwrite && hit(paddr, 2'(c), `QEMT_OFF_CONST_B);
      assign wr_ctrl = done && pwrite && hit(paddr, 2'(c), `QEMT_OFF_CONTROL);
      assign wr_stat = done && pwrite && hit(paddr, 2'(c), `QEMT_OFF_STATUS);
      assign rd_stat = done && !pwrite && hit(paddr, 2'(c), `QEMT_OFF_STATUS);
      assign sup_a   = acc && pwrite && hit(paddr, 2'(c), `QEMT_OFF_CONST_A);
      assign sup_b   = acc && pwrite && hit(paddr, 2'(c), `QEMT_OFF_CONST_B);

      // a match is the first cycle of equality
      assign eq_a  = (cnt[c] == const_a[c]) && !sup_a;
      assign eq_b  = (cnt[c] == const_b[c]) && !sup_b;
      assign ma[c] = eq_a && !eq_a_d;
      assign mb[c] = eq_b && !eq_b_d;

      // mutual cascade of a pair gives no count
      assign both_cascade = (cks == qemt_pkg::CKS_CASCADE) &&
                            (ctrl[PARTNER][`QEMT_BIT_CKS_HI:`QEMT_BIT_CKS_LO] == 3'h4);
      assign cascade_src  = (c % 2 == 0) ? wrap_evt[PARTNER] : ma[PARTNER];

      always_comb begin
        case (cks)
          qemt_pkg::CKS_OFF:      inc[c] = 1'b0;
          qemt_pkg::CKS_DIV8:     inc[c] = tick8;
          qemt_pkg::CKS_DIV64:    inc[c] = tick64;
          qemt_pkg::CKS_DIV8192:  inc[c] = tick8192;
          qemt_pkg::CKS_CASCADE:  inc[c] = cascade_src && !both_cascade;
          qemt_pkg::CKS_EXT_RISE: inc[c] = clk_rise[c / 2];
          qemt_pkg::CKS_EXT_FALL: inc[c] = clk_fall[c / 2];
          qemt_pkg::CKS_EXT_BOTH: inc[c] = clk_rise[c / 2] || clk_fall[c / 2];
          default:                inc[c] = 1'b0;
        endcase
      end

      always_comb begin
        case (csel)
          qemt_pkg::CLR_NONE:    clr[c] = 1'b0;
          qemt_pkg::CLR_MATCH_A: clr[c] = ma[c];
          qemt_pkg::CLR_MATCH_B: clr[c] = mb[c];
          qemt_pkg::CLR_EXT:     clr[c] = rst_rise[c / 2];
          default:               clr[c] = 1'b0;
        endcase
      end

      // clear beats write beats increment; no wrap on clear or write
      assign wrap_evt[c] = inc[c] && (cnt[c] == 8'hff) && !clr[c] && !wr_cnt;

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt[c] <= `QEMT_RST_COUNT;
        end else if (clr[c]) begin
          cnt[c] <= 8'h00;
        end else if (wr_cnt) begin
          cnt[c] <= wbyte;
        end else if (inc[c]) begin
          cnt[c] <= cnt[c] + 8'h01;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          const_a[c] <= `QEMT_RST_CONST;
          const_b[c] <= `QEMT_RST_CONST;
          ctrl[c]    <= `QEMT_RST_CONTROL;
          out_sel[c] <= `QEMT_RST_OUT_SEL;
        end else begin
          if (wr_ca) begin
            const_a[c] <= wbyte;
          end
          if (wr_cb) begin
            const_b[c] <= wbyte;
          end
          if (wr_ctrl) begin
            ctrl[c] <= pwdata[7:0];
          end
          if (wr_stat) begin
            out_sel[c] <= pwdata[`QEMT_BIT_OS_B_HI:`QEMT_BIT_OS_A_LO];
          end
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          eq_a_d <= 1'b0;
          eq_b_d <= 1'b0;
        end else begin
          eq_a_d <= eq_a;
          eq_b_d <= eq_b;
        end
      end

      // clear needs a prior read of one; a new event beats the clear
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          seen_a    <= 1'b0;
          seen_b    <= 1'b0;
          seen_w    <= 1'b0;
          flag_a[c] <= 1'b0;
          flag_b[c] <= 1'b0;
          flag_w[c] <= 1'b0;
        end else begin
          seen_a    <= (rd_stat && flag_a[c]) || (seen_a && !wr_stat);
          seen_b    <= (rd_stat && flag_b[c]) || (seen_b && !wr_stat);
          seen_w    <= (rd_stat && flag_w[c]) || (seen_w && !wr_stat);
          flag_a[c] <= ma[c] || (flag_a[c] && !(wr_stat && seen_a && !pwdata[`QEMT_BIT_FLAG_A]));
          flag_b[c] <= mb[c] || (flag_b[c] && !(wr_stat && seen_b && !pwdata[`QEMT_BIT_FLAG_B]));
          flag_w[c] <= wrap_evt[c] || (flag_w[c] && !(wr_stat && seen_w && !pwdata[`QEMT_BIT_FLAG_W]));
        end
      end

      assign pin_a = ma[c] ? apply_os(out_sel[c][`QEMT_BIT_OS_A_HI:`QEMT_BIT_OS_A_LO], channel_output_pin[c])
                           : channel_output_pin[c];

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          channel_output_pin[c] <= 1'b0;
          match_a_irq[c]        <= 1'b0;
          match_b_irq[c]        <= 1'b0;
          wrap_irq[c]           <= 1'b0;
        end else begin
          channel_output_pin[c] <= mb[c] ? apply_os(out_sel[c][`QEMT_BIT_OS_B_HI:`QEMT_BIT_OS_B_LO], pin_a)
                                         : pin_a;
          match_b_irq[c] <= flag_b[c] && ctrl[c][`QEMT_BIT_MB_IE];
          match_a_irq[c] <= flag_a[c] && ctrl[c][`QEMT_BIT_MA_IE];
          wrap_irq[c]    <= flag_w[c] && ctrl[c][`QEMT_BIT_WRAP_IE];
        end
      end

      sequence s_read_flag_a;
        rd_stat && flag_a[c];
      endsequence
      sequence s_write_zero_a;
        wr_stat && !pwdata[`QEMT_BIT_FLAG_A] && !ma[c];
      endsequence

      property p_wrap_flag;
        wrap_evt[c] |=> flag_w[c];
      endproperty
      a_wrap_flag: assert property (p_wrap_flag) else $error("wrap did not set flag");
      property p_wrap_value;
        wrap_evt[c] |=> cnt[c] == 8'h00;
      endproperty
      a_wrap_value: assert property (p_wrap_value) else $error("counter not zero after wrap");
      property p_match_a;
        ma[c] |=> flag_a[c] && $past(cnt[c]) == $past(const_a[c]);
      endproperty
      a_match_a: assert property (p_match_a) else $error("match a flag wrong");
      property p_suppress_b;
        sup_b && !flag_b[c] |=> !flag_b[c];
      endproperty
      a_suppress_b: assert property (p_suppress_b) else $error("match b during constant write");
      property p_irq_b;
        flag_b[c] && ctrl[c][`QEMT_BIT_MB_IE] ##1 flag_b[c] |-> match_b_irq[c];
      endproperty
      a_irq_b: assert property (p_irq_b) else $error("match b request missing");
      property p_irq_w_off;
        !flag_w[c] |=> !wrap_irq[c];
      endproperty
      a_irq_w_off: assert property (p_irq_w_off) else $error("wrap request without flag");
      property p_clear_b;
        csel == qemt_pkg::CLR_MATCH_B && mb[c] |=> cnt[c] == 8'h00;
      endproperty
      a_clear_b: assert property (p_clear_b) else $error("no clear on match b");
      property p_hold_off;
        cks == qemt_pkg::CKS_OFF && !clr[c] && !wr_cnt |=> cnt[c] == $past(cnt[c]);
      endproperty
      a_hold_off: assert property (p_hold_off) else $error("counter moved with no source");
      property p_toggle_a;
        ma[c] && !mb[c] && out_sel[c][1:0] == 2'b11 |=> channel_output_pin[c] != $past(channel_output_pin[c]);
      endproperty
      a_toggle_a: assert property (p_toggle_a) else $error("output did not toggle");
      property p_read_then_clear;
        s_read_flag_a ##1 (!wr_stat)[*3] ##1 s_write_zero_a |=> !flag_a[c];
      endproperty
      a_read_then_clear: assert property (p_read_then_clear) else $error("flag a not cleared");
      property p_write_one_kept;
        flag_a[c] && wr_stat && pwdata[`QEMT_BIT_FLAG_A] |=> flag_a[c];
      endproperty
      a_write_one_kept: assert property (p_write_one_kept) else $error("flag a cleared by one");
    end
  endgenerate

endmodule

/* File: testbench/qemt_pin_model.sv */
// drives one channel pair's external count-clock and counter-reset pins
// assumes pclk from the bench; both pins idle low outside bursts
`timescale 1ns/1ps
module qemt_pin_model (
  // clock
  input  wire logic pclk,
  // pair pins
  output logic      clk_pin,
  output logic      rst_pin
);
  initial begin
    clk_pin = 1'b0;
    rst_pin = 1'b0;
  end

  // levels held 4 cycles so the synchroniser sees every edge
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge pclk);
      clk_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      clk_pin <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask

  task automatic reset_pulse();
    @(posedge pclk);
    rst_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    rst_pin <= 1'b0;
  endtask
endmodule

/* File: testbench/test_quad_eight_bit_match_timer.sv */
// self-checking bench of the four-channel match timer over apb
// assumes the timer top, its constants header and the pin model
`timescale 1ns/1ps
`include "qemt_params.svh"
module test_quad_eight_bit_match_timer;
  logic        pclk;
  logic        presetn;
  logic        psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pa_clk, pa_rst, pb_clk, pb_rst;
  logic [3:0]  out_pin, ma_irq, mb_irq, w_irq;
  int          err_total, n_compared, seed, cyc, n, t;
  logic        exp_o;

  qemt_top qemt_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pair_a_ext_clock_pin(pa_clk), .pair_a_ext_reset_pin(pa_rst),
    .pair_b_ext_clock_pin(pb_clk), .pair_b_ext_reset_pin(pb_rst),
    .channel_output_pin(out_pin), .match_a_irq(ma_irq), .match_b_irq(mb_irq), .wrap_irq(w_irq));
  qemt_pin_model qemt_pin_model_i (.pclk(pclk), .clk_pin(pb_clk), .rst_pin(pb_rst));
  qemt_pin_model pair_a_pins (.pclk(pclk), .clk_pin(pa_clk), .rst_pin(pa_rst));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_total++;
      results();
    end
  end

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  function automatic logic [7:0] ad(input int c, input logic [7:0] o);
    return 8'(c) * `QEMT_CHAN_STRIDE + o;
  endfunction

  function automatic logic os_next(input logic [1:0] c, input logic p);
    case (c)
      2'h0: return p;
      2'h1: return 1'b0;
      2'h2: return 1'b1;
      default: return ~p;
    endcase
  endfunction

  // cycles until output pin of channel ch shows level v
  task automatic wait_lvl(input int ch, input logic v, output int cnt);
    cnt = 0;
    while (out_pin[ch] !== v && cnt < 40000) begin
      @(posedge pclk);
      cnt++;
    end
  endtask

  initial begin
    seed = 26908;
    cyc = 0;
    err_total = 0;
    n_compared = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      rdc(ad(c, `QEMT_OFF_COUNT));   chk("count", rd[7:0], 8'h00);
      rdc(ad(c, `QEMT_OFF_CONST_A)); chk("const a", rd[7:0], 8'hff);
      rdc(ad(c, `QEMT_OFF_CONST_B)); chk("const b", rd[7:0], 8'hff);
      rdc(ad(c, `QEMT_OFF_CONTROL)); chk("control", rd[7:0], 8'h00);
      wr(ad(c, `QEMT_OFF_STATUS), 32'he0);
      rdc(ad(c, `QEMT_OFF_STATUS));  chk("status", rd[7:0], 8'h00);
    end
    rdc(8'hfc);
    chk("slverr", 32'(err), 32'h1);
    chk("unmapped", rd, 32'h0);
    t = $random(seed);
    wr(`QEMT_PAIR_BASE + 8'h04, 32'(t[15:0]));
    rdc(ad(0, `QEMT_OFF_CONST_A)); chk("pair hi", rd[7:0], t[15:8]);
    rdc(ad(1, `QEMT_OFF_CONST_A)); chk("pair lo", rd[7:0], t[7:0]);
    rdc(`QEMT_PAIR_BASE + 8'h04);  chk("pair word", 32'(rd[15:0]), 32'(t[15:0]));
    wr(ad(0, `QEMT_OFF_COUNT), 32'h42);
    repeat (50) @(posedge pclk);
    rdc(ad(0, `QEMT_OFF_COUNT)); chk("held", rd[7:0], 8'h42);
    // matches forced by writing the count onto a constant
    wr(ad(0, `QEMT_OFF_CONST_A), 32'h10);
    wr(ad(0, `QEMT_OFF_CONST_B), 32'h20);
    exp_o = 1'b0;
    n = $random(seed);
    for (int i = 0; i < 8; i++) begin
      logic [1:0] c;
      c = 2'(i + n);
      wr(ad(0, `QEMT_OFF_STATUS), i < 4 ? 32'(c) : 32'(c) << 2);
      wr(ad(0, `QEMT_OFF_COUNT), i < 4 ? 32'h10 : 32'h20);
      repeat (4) @(posedge pclk);
      exp_o = os_next(c, exp_o);
      chk("out", 32'(out_pin[0]), 32'(exp_o));
      wr(ad(0, `QEMT_OFF_COUNT), 32'h00);
    end
    rdc(ad(0, `QEMT_OFF_STATUS));
    chk("flag a", 32'(rd[6]), 32'h1);
    chk("flag b", 32'(rd[7]), 32'h1);
    wr(ad(0, `QEMT_OFF_STATUS), 32'he0);
    rdc(ad(0, `QEMT_OFF_STATUS)); chk("ones kept", 32'(rd[7:6]), 32'h3);
    wr(ad(0, `QEMT_OFF_CONTROL), 32'h80);
    repeat (3) @(posedge pclk);
    chk("irq b", {mb_irq[0], ma_irq[0]}, 2'b10);
    wr(ad(0, `QEMT_OFF_CONTROL), 32'h40);
    repeat (3) @(posedge pclk);
    chk("irq a", {mb_irq[0], ma_irq[0]}, 2'b01);
    rdc(ad(0, `QEMT_OFF_STATUS)); chk("armed", 32'(rd[7:6]), 32'h3);
    wr(ad(0, `QEMT_OFF_STATUS), 32'h00);
    rdc(ad(0, `QEMT_OFF_STATUS)); chk("cleared", 32'(rd[7:5]), 32'h0);
    chk("irq off", 32'(ma_irq[0]), 32'h0);
    wr(ad(0, `QEMT_OFF_CONTROL), 32'h00);
    // 16-bit cascade on pair a
    wr(`QEMT_PAIR_BASE, 32'h05fe);
    wr(ad(0, `QEMT_OFF_CONTROL), 32'h04);
    wr(ad(1, `QEMT_OFF_CONTROL), 32'h21);
    repeat (40) @(posedge pclk);
    rdc(ad(1, `QEMT_OFF_STATUS)); chk("wrap", 32'(rd[5]), 32'h1);
    chk("wrap irq", 32'(w_irq[1]), 32'h1);
    rdc(ad(0, `QEMT_OFF_COUNT)); chk("upper", rd[7:0], 8'h06);
    wr(ad(0, `QEMT_OFF_CONTROL), 32'h00);
    // pair b: upper match a counted by lower
    wr(ad(2, `QEMT_OFF_CONST_A), 32'h01);
    wr(ad(3, `QEMT_OFF_CONTROL), 32'h04);
    wr(ad(2, `QEMT_OFF_CONTROL), 32'h09);
    repeat (160) @(posedge pclk);
    wr(ad(2, `QEMT_OFF_CONTROL), 32'h00);
    // ch2 clears in its match cycle: one match a per tick, 164 cycles at div 8
    rdc(ad(3, `QEMT_OFF_COUNT)); chk("match count", 32'(rd[7:0] >= 20 && rd[7:0] <= 21), 32'h1);
    wr(`QEMT_PAIR_BASE + `QEMT_PAIR_STRIDE, 32'h0);
    wr(ad(2, `QEMT_OFF_CONTROL), 32'h05);
    wr(ad(3, `QEMT_OFF_CONTROL), 32'h07);
    qemt_pin_model_i.pulses(5);
    repeat (8) @(posedge pclk);
    rdc(`QEMT_PAIR_BASE + `QEMT_PAIR_STRIDE); chk("ext rise", 32'(rd[15:0]), 32'h050a);
    wr(ad(2, `QEMT_OFF_CONTROL), 32'h06);
    qemt_pin_model_i.pulses(3);
    repeat (8) @(posedge pclk);
    rdc(`QEMT_PAIR_BASE + `QEMT_PAIR_STRIDE); chk("ext fall", 32'(rd[15:0]), 32'h0810);
    wr(ad(2, `QEMT_OFF_CONTROL), 32'h1e);
    wr(ad(3, `QEMT_OFF_CONTROL), 32'h1f);
    qemt_pin_model_i.reset_pulse();
    repeat (8) @(posedge pclk);
    rdc(`QEMT_PAIR_BASE + `QEMT_PAIR_STRIDE); chk("ext clear", 32'(rd[15:0]), 32'h0);
    // pair a pins: rising count, then pin clear
    wr(ad(1, `QEMT_OFF_CONTROL), 32'h05);
    wr(ad(1, `QEMT_OFF_COUNT), 32'h00);
    pair_a_pins.pulses(2);
    repeat (8) @(posedge pclk);
    rdc(ad(1, `QEMT_OFF_COUNT)); chk("pair a ext", rd[7:0], 8'h02);
    wr(ad(1, `QEMT_OFF_CONTROL), 32'h1d);
    pair_a_pins.reset_pulse();
    repeat (8) @(posedge pclk);
    rdc(ad(1, `QEMT_OFF_COUNT)); chk("pair a clear", rd[7:0], 8'h00);
    // prescaler: high at match a, low at match b, width (b-a)*div
    for (int k = 1; k < 4; k++) begin
      int a, b, div, cnt;
      div = k == 1 ? 8 : k == 2 ? 64 : 8192;
      a = k == 3 ? 1 : 1 + {$random(seed)} % 3;
      b = k == 3 ? 2 : a + 1 + {$random(seed)} % 4;
      wr(ad(1, `QEMT_OFF_CONTROL), 32'h00);
      wr(ad(1, `QEMT_OFF_STATUS), 32'h06);
      wr(ad(1, `QEMT_OFF_CONST_B), 32'(b));
      wr(ad(1, `QEMT_OFF_COUNT), 32'(b));
      wr(ad(1, `QEMT_OFF_CONST_A), 32'(a));
      wr(ad(1, `QEMT_OFF_COUNT), 32'h00);
      wr(ad(1, `QEMT_OFF_CONTROL), 32'(k));
      wait_lvl(1, 1'b1, cnt);
      wait_lvl(1, 1'b0, cnt);
      chk("width", 32'(cnt), 32'((b - a) * div));
      if (k == 1) begin
        for (int s = 0; s < 3; s++) begin
          wr(ad(1, `QEMT_OFF_CONTROL), 32'h00);
          wr(ad(1, `QEMT_OFF_COUNT), 32'h00);
          wr(ad(1, `QEMT_OFF_CONTROL), 32'((s << 3) | 1));
          repeat (600) @(posedge pclk);
          rdc(ad(1, `QEMT_OFF_COUNT));
          chk("clear", 32'(s == 0 ? rd[7:0] > b : rd[7:0] <= (s == 1 ? a : b)), 32'h1);
        end
      end
    end
    results();
  end
endmodule
